// >>> rtl/refclk_pkg.sv
// constants and types shared by the reference clock and power-save controller
`default_nettype none
package refclk_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  REF_CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  OSC_CTRL_OFFSET   = 8'h04;
	localparam logic [7:0]  PWR_STAT_OFFSET   = 8'h08;

	// ------------------------------------------------------------
	// reference_clock_control fields
	// ------------------------------------------------------------
	localparam int          REF_EN_BIT        = 15;
	localparam int          REF_SLP_BIT       = 13;
	localparam int          REF_SEL_BIT       = 12;
	localparam int          REF_DIV_LSB       = 8;
	localparam int          REF_DIV_WIDTH     = 4;
	localparam logic [15:0] REF_WRITE_MASK    = 16'hBF00;
	localparam logic [15:0] REF_CTRL_RESET    = 16'h0000;

	// ------------------------------------------------------------
	// oscillator_control fields and unlock keys
	// ------------------------------------------------------------
	localparam int          CUR_SRC_LSB       = 12;
	localparam int          NEXT_SRC_LSB      = 8;
	localparam int          SWITCH_BIT        = 0;
	localparam int          SRC_WIDTH         = 3;
	localparam logic [2:0]  SRC_RESET         = 3'h0;
	localparam logic [7:0]  HIGH_KEY_FIRST    = 8'h78;
	localparam logic [7:0]  HIGH_KEY_SECOND   = 8'h9A;
	localparam logic [7:0]  LOW_KEY_FIRST     = 8'h46;
	localparam logic [7:0]  LOW_KEY_SECOND    = 8'h57;

	// ------------------------------------------------------------
	// power-save instruction operands and states
	// ------------------------------------------------------------
	localparam logic        SLEEP_OPERAND     = 1'b0;
	localparam logic        IDLE_OPERAND      = 1'b1;

	typedef enum logic [1:0] {
		STAGE_LOCKED,
		STAGE_KEY1,
		STAGE_OPEN
	} unlock_stage_type;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_SLEEP,
		PWR_IDLE
	} power_state_type;

endpackage
`default_nettype wire

// >>> rtl/ref_divider.sv
// power-of-two divider for the reference clock output
`default_nettype none
module ref_divider #(
	parameter int DIV_WIDTH = 4
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 clear,
	input  wire logic                 base_edge,
	input  wire logic [DIV_WIDTH-1:0] div_sel,
	output logic                      clk_out
);
	localparam int CNT_WIDTH = (1 << DIV_WIDTH) - 1;

	logic [CNT_WIDTH-1:0] count_reg;
	logic [CNT_WIDTH-1:0] limit;

	// output toggles every 2**div_sel base edges, so one period spans 2**(div_sel+1) base edges
	assign limit = CNT_WIDTH'((32'h1 << div_sel) - 32'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
			clk_out   <= 1'b0;
		end else if (clear) begin
			count_reg <= '0;
			clk_out   <= 1'b0;
		end else if (base_edge) begin
			if (count_reg >= limit) begin
				count_reg <= '0;
				clk_out   <= ~clk_out;
			end else begin
				count_reg <= count_reg + CNT_WIDTH'(1);
			end
		end
	end

	property p_div_hold;
		@(posedge pclk) disable iff (!presetn)
		(!clear && !base_edge) |=> $stable(clk_out);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divider output moved without a base edge"); // R2

endmodule
`default_nettype wire

// >>> rtl/ref_clock_power_ctrl.sv
// reference clock output, oscillator control unlock and Sleep/Idle gating
`default_nettype none

// Functional notes
// R1: enable bit drives divided reference clock on pin; cleared, output disabled.
// R2: divisor field divides base clock by two to the field value, up to 32768; the code divides the system clock by twice that.
// R3: source bit one selects primary oscillator, zero selects system clock.
// R4: run-in-sleep bit keeps reference output in Sleep; otherwise output stops.
// R5: software sets run-in-sleep and source bits plus primary mode for Sleep output.
// R6: bit 14 and bits 7..0 read zero; implemented bits reset to zero.
// R7: certain oscillator modes also give a fixed half-rate clock output.
// R8: software writes 0x78 then 0x9A to high byte before new selection.
// R9: software writes 0x46 then 0x57 to low byte before setting switch start.
// R10: Sleep or Idle entered only by power-save instruction; operand picks mode.
// R11: Sleep shuts system clock, on-chip oscillators, freezes all I/O pins.
// R12: fail-safe clock monitor inactive during Sleep.
// R13: low-power oscillator runs in Sleep if watchdog or its calendar needs it.
// R14: watchdog cleared on entry to Sleep and to Idle.
// R15: Sleep disables system-clocked peripherals; external and change notification continue.
// R16: wake on enabled interrupt, any reset or watchdog time-out.
// R17: after Sleep, resume with the clock source active at entry.
// R18: Idle stops CPU, keeps system clock and peripherals running.
// R19: Idle keeps low-power oscillator if watchdog or fail-safe monitor enabled.
// R20: wake from Idle re-applies CPU clock and resumes at once.
// R21: selection write and switch start follow their unlocks immediately.
// R22: disabled or sleeping output held low; divider restarts from zero.
module ref_clock_power_ctrl
	import refclk_pkg::*;
#(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  primary_osc_pin,
	input  wire logic                  primary_mode_cfg,
	input  wire logic                  half_rate_mode_cfg,
	input  wire logic                  power_save_exec,
	input  wire logic                  power_save_operand,
	input  wire logic                  enabled_irq_pending,
	input  wire logic                  watchdog_timeout,
	input  wire logic                  watchdog_enable,
	input  wire logic                  fail_safe_enable,
	input  wire logic                  calendar_enable,
	input  wire logic                  calendar_on_low_power_internal_osc,
	output logic                       reference_clock_pin,
	output logic                       half_rate_clock_pin,
	output logic                       cpu_clock_en,
	output logic                       sys_clock_src_en,
	output logic                       periph_clock_en,
	output logic                       primary_osc_en,
	output logic                       low_power_osc_en,
	output logic                       fail_safe_active,
	output logic                       io_freeze,
	output logic                       watchdog_clear,
	output logic                       resume_pulse,
	output logic [refclk_pkg::SRC_WIDTH-1:0] active_clock_source
);
	import refclk_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [15:0]          ref_ctrl_reg;
	logic [15:0]          ref_ctrl_next;
	logic [SRC_WIDTH-1:0] next_src_reg;
	logic [SRC_WIDTH-1:0] cur_src_reg;
	logic [SRC_WIDTH-1:0] saved_src_reg;
	logic                 switch_reg;
	unlock_stage_type     high_stage_reg;
	unlock_stage_type     low_stage_reg;
	power_state_type      state_reg;
	power_state_type      state_next;
	logic                 osc_meta_reg;
	logic                 osc_sync_reg;
	logic                 osc_prev_reg;
	logic                 half_rate_reg;
	logic                 watchdog_clear_reg;
	logic                 resume_reg;
	logic                 bus_access;
	logic                 bus_write;
	logic                 sel_ref;
	logic                 sel_osc;
	logic                 sel_stat;
	logic                 high_write;
	logic                 low_write;
	logic                 ref_enable;
	logic                 ref_in_sleep;
	logic                 ref_src_primary;
	logic                 ref_running;
	logic                 base_edge;
	logic                 osc_edge;
	logic                 sleeping;
	logic                 wake_event;

	// ------------------------------------------------------------
	// apb slave: zero wait states, unmapped addresses flag an error
	// ------------------------------------------------------------
	assign bus_access = psel && penable;
	assign bus_write  = bus_access && pwrite;
	assign sel_ref    = (paddr == ADDR_WIDTH'(REF_CTRL_OFFSET));
	assign sel_osc    = (paddr == ADDR_WIDTH'(OSC_CTRL_OFFSET));
	assign sel_stat   = (paddr == ADDR_WIDTH'(PWR_STAT_OFFSET));
	assign pready     = 1'b1;
	assign high_write = bus_write && sel_osc && pstrb[1];
	assign low_write  = bus_write && sel_osc && pstrb[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !(sel_ref || sel_osc || sel_stat);
			if (pwrite || !(sel_ref || sel_osc || sel_stat)) begin
				prdata <= 32'h0000_0000;
			end else if (sel_ref) begin
				prdata <= {16'h0000, ref_ctrl_reg}; // R6
			end else if (sel_osc) begin
				prdata <= {16'h0000, 1'b0, cur_src_reg, 1'b0, next_src_reg, 7'h00, switch_reg};
			end else begin
				prdata <= {28'h0000000, io_freeze, !cpu_clock_en, state_reg};
			end
		end
	end

	// ------------------------------------------------------------
	// reference_clock_control
	// ------------------------------------------------------------
	always_comb begin
		ref_ctrl_next = ref_ctrl_reg;
		if (bus_write && sel_ref && pstrb[1]) begin
			ref_ctrl_next[15:8] = pwdata[15:8] & REF_WRITE_MASK[15:8]; // R6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_ctrl_reg <= REF_CTRL_RESET; // R6
		end else begin
			ref_ctrl_reg <= ref_ctrl_next;
		end
	end

	assign ref_enable      = ref_ctrl_reg[REF_EN_BIT];
	assign ref_in_sleep    = ref_ctrl_reg[REF_SLP_BIT];
	assign ref_src_primary = ref_ctrl_reg[REF_SEL_BIT];

	// ------------------------------------------------------------
	// primary oscillator pin: two-stage synchroniser, then edge detect
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			osc_meta_reg <= primary_osc_pin;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	// both edges count, so the pin is reproduced at divisor code zero
	assign osc_edge = osc_sync_reg ^ osc_prev_reg;

	// ------------------------------------------------------------
	// reference output path
	// ------------------------------------------------------------
	assign sleeping    = (state_reg == PWR_SLEEP);
	// the system clock is gone in Sleep, so only the primary source can keep running
	assign ref_running = ref_enable && (!sleeping || (ref_in_sleep && ref_src_primary)); // R1 R4
	assign base_edge   = ref_src_primary ? osc_edge : 1'b1; // R3

	ref_divider #(
		.DIV_WIDTH (REF_DIV_WIDTH)
	) u_divider (
		.pclk      (pclk),
		.presetn   (presetn),
		.clear     (!ref_running), // R22
		.base_edge (base_edge),
		.div_sel   (ref_ctrl_reg[REF_DIV_LSB +: REF_DIV_WIDTH]), // R2
		.clk_out   (reference_clock_pin)
	);

	// ------------------------------------------------------------
	// half-rate clock output
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_rate_reg <= 1'b0;
		end else if (half_rate_mode_cfg && !sleeping) begin
			half_rate_reg <= ~half_rate_reg; // R7
		end else begin
			half_rate_reg <= 1'b0;
		end
	end
	assign half_rate_clock_pin = half_rate_reg;

	// ------------------------------------------------------------
	// oscillator_control unlock sequences
	// ------------------------------------------------------------
	// any other completed transfer breaks the sequence, so keys must be back to back
	function automatic unlock_stage_type unlock_step(
		input unlock_stage_type stage,
		input logic             access,
		input logic             wr,
		input logic [7:0]       data,
		input logic [7:0]       key1,
		input logic [7:0]       key2
	);
		unlock_stage_type result;
		result = stage;
		if (access) begin
			if (wr && data == key1) begin
				result = STAGE_KEY1;
			end else if (wr && stage == STAGE_KEY1 && data == key2) begin
				result = STAGE_OPEN;
			end else begin
				result = STAGE_LOCKED;
			end
		end
		return result;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_stage_reg <= STAGE_LOCKED;
			low_stage_reg  <= STAGE_LOCKED;
		end else begin
			high_stage_reg <= unlock_step(high_stage_reg, bus_access, high_write,
				pwdata[15:8], HIGH_KEY_FIRST, HIGH_KEY_SECOND); // R8
			low_stage_reg  <= unlock_step(low_stage_reg, bus_access, low_write,
				pwdata[7:0], LOW_KEY_FIRST, LOW_KEY_SECOND); // R9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_src_reg <= SRC_RESET;
		end else if (high_write && high_stage_reg == STAGE_OPEN) begin
			next_src_reg <= pwdata[NEXT_SRC_LSB +: SRC_WIDTH]; // R21
		end
	end

	// switch completes one cycle after start; oscillator start-up is outside this block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_reg <= 1'b0;
		end else if (low_write && low_stage_reg == STAGE_OPEN && pwdata[SWITCH_BIT]) begin
			switch_reg <= 1'b1; // R21
		end else begin
			switch_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_src_reg   <= SRC_RESET;
			saved_src_reg <= SRC_RESET;
		end else begin
			if (state_reg == PWR_RUN && state_next == PWR_SLEEP) begin
				saved_src_reg <= cur_src_reg;
			end
			if (state_reg == PWR_SLEEP && state_next == PWR_RUN) begin
				cur_src_reg <= saved_src_reg; // R17
			end else if (switch_reg && !sleeping) begin
				cur_src_reg <= next_src_reg;
			end
		end
	end
	assign active_clock_source = cur_src_reg;

	// ------------------------------------------------------------
	// power-save state machine
	// ------------------------------------------------------------
	assign wake_event = enabled_irq_pending || watchdog_timeout; // R16

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PWR_RUN: begin
				if (power_save_exec) begin // R10
					state_next = (power_save_operand == SLEEP_OPERAND) ? PWR_SLEEP : PWR_IDLE;
				end
			end
			PWR_SLEEP, PWR_IDLE: begin
				if (wake_event) begin
					state_next = PWR_RUN; // R16 R20
				end
			end
			default: begin
				state_next = PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= PWR_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_clear_reg <= 1'b0;
			resume_reg         <= 1'b0;
		end else begin
			watchdog_clear_reg <= watchdog_enable && state_reg == PWR_RUN
				&& state_next != PWR_RUN; // R14
			resume_reg <= state_reg != PWR_RUN && state_next == PWR_RUN;
		end
	end
	assign watchdog_clear = watchdog_clear_reg;
	assign resume_pulse   = resume_reg;

	// ------------------------------------------------------------
	// clock and oscillator gating
	// ------------------------------------------------------------
	assign cpu_clock_en     = (state_reg == PWR_RUN); // R18 R20
	assign sys_clock_src_en = !sleeping; // R11 R18
	assign periph_clock_en  = !sleeping; // R15 R18
	assign io_freeze        = sleeping; // R11
	assign fail_safe_active = fail_safe_enable && !sleeping; // R12
	assign primary_osc_en   = primary_mode_cfg && (!sleeping || (ref_enable && ref_in_sleep
		&& ref_src_primary)); // R5 R11
	always_comb begin
		unique case (state_reg)
			PWR_SLEEP: low_power_osc_en = watchdog_enable
				|| (calendar_enable && calendar_on_low_power_internal_osc); // R13
			PWR_IDLE:  low_power_osc_en = watchdog_enable || fail_safe_enable
				|| (calendar_enable && calendar_on_low_power_internal_osc); // R19
			default:   low_power_osc_en = watchdog_enable || fail_safe_enable
				|| (calendar_enable && calendar_on_low_power_internal_osc);
		endcase
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_ref_low_when_off;
		@(posedge pclk) disable iff (!presetn)
		!ref_running |=> !reference_clock_pin;
	endproperty
	a_ref_low_when_off: assert property (p_ref_low_when_off) else $error("reference pin not held low"); // R22

	property p_ref_sleep_stop;
		@(posedge pclk) disable iff (!presetn)
		(sleeping && !ref_in_sleep) [*2] |-> !reference_clock_pin;
	endproperty
	a_ref_sleep_stop: assert property (p_ref_sleep_stop) else $error("reference ran in sleep"); // R4

	property p_ref_toggles;
		@(posedge pclk) disable iff (!presetn)
		(ref_running && !ref_src_primary && ref_ctrl_reg[11:8] == 4'h0) [*3]
			|-> reference_clock_pin != $past(reference_clock_pin);
	endproperty
	a_ref_toggles: assert property (p_ref_toggles) else $error("undivided system reference stuck"); // R1

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		ref_ctrl_reg[14] == 1'b0 && ref_ctrl_reg[7:0] == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // R6

	property p_enter_only_by_instr;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == PWR_RUN && !power_save_exec) |=> state_reg == PWR_RUN;
	endproperty
	a_enter_only_by_instr: assert property (p_enter_only_by_instr) else $error("left run unasked"); // R10

	property p_sleep_gating;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == PWR_RUN && power_save_exec && power_save_operand == SLEEP_OPERAND)
			|=> io_freeze && !sys_clock_src_en && !periph_clock_en && !fail_safe_active;
	endproperty
	a_sleep_gating: assert property (p_sleep_gating) else $error("sleep gating wrong"); // R11

	property p_idle_gating;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == PWR_RUN && power_save_exec && power_save_operand == IDLE_OPERAND)
			|=> !cpu_clock_en && sys_clock_src_en && periph_clock_en;
	endproperty
	a_idle_gating: assert property (p_idle_gating) else $error("idle gating wrong"); // R18

	property p_wdt_clear;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == PWR_RUN && power_save_exec && watchdog_enable) |=> watchdog_clear;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared"); // R14

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		(state_reg != PWR_RUN && wake_event) |=> cpu_clock_en && resume_pulse;
	endproperty
	a_wake: assert property (p_wake) else $error("missed wake-up"); // R16

	property p_source_kept;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == PWR_SLEEP && state_next == PWR_RUN)
			|=> cur_src_reg == $past(saved_src_reg);
	endproperty
	a_source_kept: assert property (p_source_kept) else $error("source changed over sleep"); // R17

	property p_low_power_internal_osc_sleep;
		@(posedge pclk) disable iff (!presetn)
		(sleeping && watchdog_enable) |-> low_power_osc_en;
	endproperty
	a_low_power_internal_osc_sleep: assert property (p_low_power_internal_osc_sleep) else $error("low_power_internal_osc off with watchdog"); // R13

	property p_low_power_internal_osc_idle;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == PWR_IDLE && fail_safe_enable) |-> low_power_osc_en;
	endproperty
	a_low_power_internal_osc_idle: assert property (p_low_power_internal_osc_idle) else $error("low_power_internal_osc off in idle"); // R19

	property p_half_rate;
		@(posedge pclk) disable iff (!presetn)
		(half_rate_mode_cfg && !sleeping) [*2] |-> half_rate_clock_pin != $past(half_rate_clock_pin);
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("half-rate clock stuck"); // R7

	property p_posc_sleep_off;
		@(posedge pclk) disable iff (!presetn)
		(sleeping && !(ref_enable && ref_in_sleep && ref_src_primary)) |-> !primary_osc_en;
	endproperty
	a_posc_sleep_off: assert property (p_posc_sleep_off) else $error("primary osc left on"); // R5

endmodule
`default_nettype wire

// >>> sim/ref_clock_sink.sv
// reference clock consumer model: counts rising edges and the last period
`default_nettype none
module ref_clock_sink (
	input  wire logic   pclk,
	input  wire logic   ref_in,
	output logic [31:0] edges,
	output logic [31:0] period
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        prev_reg = 1'b0;
	logic [31:0] gap_reg  = 32'h0;
	initial edges = 32'h0;
	initial period = 32'h0;
	// pin is registered on pclk, so pclk sampling sees every level
	always @(posedge pclk) begin
		prev_reg <= ref_in;
		gap_reg <= (ref_in && !prev_reg) ? 32'h1 : gap_reg + 32'h1;
		if (ref_in && !prev_reg) begin
			edges <= edges + 32'h1;
			period <= gap_reg;
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the reference clock and power-save controller
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import refclk_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        primary_mode_cfg = 1'b1, half_rate_mode_cfg = 1'b1, power_save_exec = 1'b0;
	logic        power_save_operand = 1'b0, enabled_irq_pending = 1'b0, watchdog_timeout = 1'b0;
	logic        watchdog_enable = 1'b1, fail_safe_enable = 1'b1, err, h;
	logic [7:0]  paddr = 8'h00;
	logic [3:0]  pstrb = 4'h0;
	logic [2:0]  osc_cnt = 3'h0;
	logic [2:0]  active_clock_source;
	logic [31:0] pwdata = 32'h0, prdata, rd, c, edges, period;
	logic        pready, pslverr, reference_clock_pin, half_rate_clock_pin, cpu_clock_en;
	logic        sys_clock_src_en, periph_clock_en, primary_osc_en, low_power_osc_en;
	logic        fail_safe_active, io_freeze, watchdog_clear, resume_pulse;
	int          bad_count = 0, checks_done = 0;

	ref_clock_power_ctrl #(.ADDR_WIDTH(8)) dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .primary_osc_pin(osc_cnt[2]), .primary_mode_cfg, .half_rate_mode_cfg,
		.power_save_exec, .power_save_operand, .enabled_irq_pending, .watchdog_timeout,
		.watchdog_enable, .fail_safe_enable, .calendar_enable(1'b0), .calendar_on_low_power_internal_osc(1'b0),
		.reference_clock_pin, .half_rate_clock_pin, .cpu_clock_en, .sys_clock_src_en,
		.periph_clock_en, .primary_osc_en, .low_power_osc_en, .fail_safe_active, .io_freeze,
		.watchdog_clear, .resume_pulse, .active_clock_source
	);
	ref_clock_sink sink_u (.pclk, .ref_in(reference_clock_pin), .edges, .period);

	always #5 pclk = ~pclk;
	// primary oscillator stand-in with a period of 8 pclk
	always @(posedge pclk) osc_cnt <= osc_cnt + 3'h1;

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	// one idle edge after release, so psel never drops and rises in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic enter(input logic op);
		@(posedge pclk);
		power_save_operand <= op;
		power_save_exec <= 1'b1;
		@(posedge pclk);
		power_save_exec <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic wake(input logic by_irq);
		@(posedge pclk);
		enabled_irq_pending <= by_irq;
		watchdog_timeout <= ~by_irq;
		@(posedge pclk);
		enabled_irq_pending <= 1'b0;
		watchdog_timeout <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic t_regs;
		apb(1'b0, REF_CTRL_OFFSET, 32'h0, 4'h0);
		check("ref reset", 32'h0, rd);
		apb(1'b1, REF_CTRL_OFFSET, 32'hFFFF_FFFF, 4'hF);
		apb(1'b0, REF_CTRL_OFFSET, 32'h0, 4'h0);
		check("ref mask", 32'h0000_BF00, rd);
		apb(1'b0, 8'h0C, 32'h0, 4'h0);
		check("unmapped", 32'h1, {31'h0, err});
		@(negedge pclk) h = half_rate_clock_pin;
		@(negedge pclk) check("half rate", {31'h0, ~h}, half_rate_clock_pin);
		$display("test regs done");
	endtask

	task automatic t_div;
		for (int n = 0; n < 4; n++) begin
			apb(1'b1, REF_CTRL_OFFSET, 32'h8000 | (n << 8), 4'h2);
			repeat (70) @(posedge pclk);
			check("sys period", 32'h2 << n, period);
		end
		apb(1'b1, REF_CTRL_OFFSET, 32'h9100, 4'h2);
		repeat (70) @(posedge pclk);
		check("osc period", 32'h10, period);
		apb(1'b1, REF_CTRL_OFFSET, 32'h0100, 4'h2);
		@(negedge pclk) c = edges;
		repeat (40) @(posedge pclk);
		check("off edges", c, edges);
		check("off level", 32'h0, reference_clock_pin);
		$display("test divider done");
	endtask

	task automatic t_unlock;
		apb(1'b1, OSC_CTRL_OFFSET, 32'h0300, 4'h2);
		apb(1'b0, OSC_CTRL_OFFSET, 32'h0, 4'h0);
		check("locked sel", 32'h0, rd[10:8]);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h7800, 4'h2);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h9A00, 4'h2);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h0300, 4'h2);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h46, 4'h1);
		apb(1'b0, OSC_CTRL_OFFSET, 32'h0, 4'h0);
		check("open sel", 32'h3, rd[10:8]);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h57, 4'h1);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h01, 4'h1);
		check("broken key", 32'h0, active_clock_source);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h46, 4'h1);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h57, 4'h1);
		apb(1'b1, OSC_CTRL_OFFSET, 32'h01, 4'h1);
		apb(1'b0, OSC_CTRL_OFFSET, 32'h0, 4'h0);
		check("switched", 32'h3300, rd & 32'h7701);
		$display("test unlock done");
	endtask

	task automatic t_sleep;
		apb(1'b1, REF_CTRL_OFFSET, 32'h8000, 4'h2);
		enter(SLEEP_OPERAND);
		check("wd clear", 32'h1, watchdog_clear);
		check("freeze", 32'h1, {31'h0, io_freeze & ~sys_clock_src_en});
		check("periph", 32'h0, periph_clock_en);
		check("fail_safe_clock_monitor", 32'h0, fail_safe_active);
		check("low_power_internal_osc", 32'h1, low_power_osc_en);
		repeat (4) @(posedge pclk);
		c = edges;
		repeat (20) @(posedge pclk);
		check("sleep edges", c, edges);
		wake(1'b1);
		check("resume", 32'h1, {31'h0, resume_pulse & cpu_clock_en});
		check("src kept", 32'h3, active_clock_source);
		apb(1'b1, REF_CTRL_OFFSET, 32'hB000, 4'h2);
		enter(SLEEP_OPERAND);
		check("posc on", 32'h1, primary_osc_en);
		repeat (60) @(posedge pclk);
		check("sleep period", 32'h8, period);
		wake(1'b0);
		check("wdt wake", 32'h1, resume_pulse);
		$display("test sleep done");
	endtask

	task automatic t_idle;
		enter(IDLE_OPERAND);
		check("idle cpu", 32'h0, cpu_clock_en);
		check("idle clk", 32'h1, {31'h0, sys_clock_src_en & periph_clock_en});
		check("idle wd", 32'h1, watchdog_clear);
		check("idle low_power_internal_osc", 32'h1, low_power_osc_en);
		enter(SLEEP_OPERAND);
		check("no reentry", 32'h0, io_freeze);
		wake(1'b1);
		check("idle resume", 32'h1, {31'h0, resume_pulse & cpu_clock_en});
		$display("test idle done");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_div();
		t_unlock();
		t_sleep();
		t_idle();
		end_sim();
	end

	// run needs about 600 cycles; far above that means a hang
	initial begin
		#100us;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
